// *** shu_shift_unit.sv ***
`timescale 1ns/1ps
module shu_shift_unit
(
   input  wire logic                  clock,
   input  wire logic                  srst,
   input  wire shu_pkg::shu_axi_req_s axi_req,
   output      shu_pkg::shu_axi_rsp_s axi_rsp
);
   import shu_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Sign bit is bit 31 here; the big-endian bit 0 of the source
   function automatic shu_res_s shift_calc(input shu_op_e     op,
                                           input logic [31:0] src,
                                           input logic [5:0]  amt,
                                           input logic [4:0]  imm);
      shu_res_s    r;
      logic [4:0]  n;
      logic        big;
      logic [31:0] lost;
      r    = '0;
      n    = (op == SHU_OP_SRAWI) ? imm : amt[4:0];
      big  = (op != SHU_OP_SRAWI) && amt[SHU_AMT_BIG_BIT];
      lost = big ? src : (src & ~(32'hFFFF_FFFF << n));
      case (op)
         SHU_OP_SLW:
         begin
            r.value     = big ? SHU_RST_WORD : (src << n);
            r.carry_upd = 1'b0;
         end
         SHU_OP_SRW:
         begin
            r.value     = big ? SHU_RST_WORD : (src >> n);
            r.carry_upd = 1'b0;
         end
         SHU_OP_SRAWI, SHU_OP_SRAW:
         begin
            // Zero count loses nothing, so carry clears by itself
            r.value     = big ? {32{src[31]}}
                              : 32'($signed(src) >>> n);
            r.carry     = src[31] && (|lost);
            r.carry_upd = 1'b1;
         end
         default:
         begin
            r = '0;
         end
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic                  aw_held_reg;
   logic [SHU_ADDR_W-1:0] aw_addr_reg;
   logic                  w_held_reg;
   logic [31:0]           w_data_reg;
   logic [3:0]            w_strb_reg;
   logic                  bvalid_reg;
   logic [1:0]            bresp_reg;
   logic                  rvalid_reg;
   logic [31:0]           rdata_reg;
   logic [1:0]            rresp_reg;

   logic [31:0]           src_gpr_reg;
   logic [31:0]           amount_gpr_reg;
   shu_cmd_s              cmd_reg;
   logic [31:0]           dest_gpr_reg;
   logic [1:0]            fixed_point_exception_reg;
   logic [3:0]            result_cond_field_reg;

   logic                  aw_fire;
   logic                  w_fire;
   logic                  ar_fire;
   logic                  wr_do;
   logic                  exec;
   shu_cmd_s              cmd_next;
   shu_res_s              res;
   logic                  wr_ok;
   logic                  rd_ok;
   logic [31:0]           rd_word;

   assign axi_rsp.awready = !aw_held_reg && !bvalid_reg;
   assign axi_rsp.wready  = !w_held_reg && !bvalid_reg;
   assign axi_rsp.bvalid  = bvalid_reg;
   assign axi_rsp.bresp   = bresp_reg;
   assign axi_rsp.arready = !rvalid_reg;
   assign axi_rsp.rvalid  = rvalid_reg;
   assign axi_rsp.rdata   = rdata_reg;
   assign axi_rsp.rresp   = rresp_reg;

   assign aw_fire  = axi_req.awvalid && axi_rsp.awready;
   assign w_fire   = axi_req.wvalid && axi_rsp.wready;
   assign ar_fire  = axi_req.arvalid && axi_rsp.arready;
   // Write lands one cycle after both halves are held
   assign wr_do    = aw_held_reg && w_held_reg;
   assign exec     = wr_do && (aw_addr_reg == SHU_OFS_CMD);
   assign cmd_next = shu_cmd_s'(merge_strb(32'(cmd_reg), w_data_reg,
                                           w_strb_reg));
   assign res      = shift_calc(cmd_next.op, src_gpr_reg,
                                amount_gpr_reg[5:0],
                                cmd_next.imm_count_field);

   always_comb
   begin
      case (aw_addr_reg)
         SHU_OFS_SRC, SHU_OFS_AMOUNT,
         SHU_OFS_CMD, SHU_OFS_FXER: wr_ok = 1'b1;
         default:                   wr_ok = 1'b0;
      endcase
   end

   always_comb
   begin
      rd_ok   = 1'b1;
      rd_word = SHU_RST_WORD;
      case (axi_req.araddr)
         SHU_OFS_SRC:    rd_word = src_gpr_reg;
         SHU_OFS_AMOUNT: rd_word = amount_gpr_reg;
         SHU_OFS_CMD:    rd_word = 32'(cmd_reg);
         SHU_OFS_DEST:   rd_word = dest_gpr_reg;
         SHU_OFS_FXER:   rd_word = {30'h0000_0000,
                                    fixed_point_exception_reg};
         SHU_OFS_COND:   rd_word = {28'h000_0000, result_cond_field_reg};
         default:        rd_ok   = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_held_reg  <= 1'b0;
         w_data_reg  <= SHU_RST_WORD;
         w_strb_reg  <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= SHU_RESP_OKAY;
      end
      else
      begin
         if (aw_fire)
         begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= axi_req.awaddr;
         end
         if (w_fire)
         begin
            w_held_reg <= 1'b1;
            w_data_reg <= axi_req.wdata;
            w_strb_reg <= axi_req.wstrb;
         end
         if (wr_do)
         begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_ok ? SHU_RESP_OKAY : SHU_RESP_SLVERR;
         end
         else if (bvalid_reg && axi_req.bready)
         begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= SHU_RST_WORD;
         rresp_reg  <= SHU_RESP_OKAY;
      end
      else if (ar_fire)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_word;
         rresp_reg  <= rd_ok ? SHU_RESP_OKAY : SHU_RESP_SLVERR;
      end
      else if (rvalid_reg && axi_req.rready)
      begin
         rvalid_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Operand and command registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         src_gpr_reg    <= SHU_RST_WORD;
         amount_gpr_reg <= SHU_RST_WORD;
         cmd_reg        <= '0;
      end
      else if (wr_do)
      begin
         if (aw_addr_reg == SHU_OFS_SRC)
         begin
            src_gpr_reg <= merge_strb(src_gpr_reg, w_data_reg, w_strb_reg);
         end
         if (aw_addr_reg == SHU_OFS_AMOUNT)
         begin
            amount_gpr_reg <= merge_strb(amount_gpr_reg, w_data_reg,
                                         w_strb_reg);
         end
         if (exec)
         begin
            cmd_reg <= cmd_next;
         end
      end
   end

   // ----------------------------------------------------------------
   // Shift execution and writeback
   // ----------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         dest_gpr_reg              <= SHU_RST_WORD;
         fixed_point_exception_reg <= 2'b00;
         result_cond_field_reg     <= SHU_RST_COND;
      end
      else if (exec)
      begin
         dest_gpr_reg <= res.value;
         if (res.carry_upd)
         begin
            fixed_point_exception_reg[SHU_FXER_CA_BIT] <= res.carry;
         end
         if (cmd_next.dot)
         begin
            // Order: negative, positive, zero, summary overflow
            result_cond_field_reg <= {res.value[31],
                                      !res.value[31] && (|res.value),
                                      ~(|res.value),
                                      fixed_point_exception_reg
                                         [SHU_FXER_SO_BIT]};
         end
      end
      else if (wr_do && (aw_addr_reg == SHU_OFS_FXER) && w_strb_reg[0])
      begin
         // Software may clear or preset the flags between shifts
         fixed_point_exception_reg <= w_data_reg[1:0];
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_SLW_VALUE: assert property (@(posedge clock) disable iff (srst)
      exec && cmd_next.op == SHU_OP_SLW && !amount_gpr_reg[5]
      |=> dest_gpr_reg == ($past(src_gpr_reg) << $past(amount_gpr_reg[4:0])))
      else $error("Left shift result wrong");

   AST_SRW_VALUE: assert property (@(posedge clock) disable iff (srst)
      exec && cmd_next.op == SHU_OP_SRW && !amount_gpr_reg[5]
      |=> dest_gpr_reg == ($past(src_gpr_reg) >> $past(amount_gpr_reg[4:0])))
      else $error("Right logical shift result wrong");

   AST_LOGIC_BIG: assert property (@(posedge clock) disable iff (srst)
      exec && !cmd_next.op[1] && amount_gpr_reg[5]
      |=> dest_gpr_reg == 32'h0000_0000)
      else $error("Logical shift of 32 or more not zero");

   AST_SRAWI_VALUE: assert property (@(posedge clock) disable iff (srst)
      exec && cmd_next.op == SHU_OP_SRAWI
      |=> dest_gpr_reg == 32'($signed($past(src_gpr_reg))
                              >>> $past(cmd_next.imm_count_field)))
      else $error("Immediate arithmetic shift result wrong");

   AST_SRA_SIGN: assert property (@(posedge clock) disable iff (srst)
      exec && cmd_next.op[1] && src_gpr_reg[31]
      |=> dest_gpr_reg[31])
      else $error("Arithmetic shift lost the sign");

   AST_SRA_CARRY: assert property (@(posedge clock) disable iff (srst)
      exec && cmd_next.op[1] && !src_gpr_reg[31]
      |=> !fixed_point_exception_reg[SHU_FXER_CA_BIT])
      else $error("Carry set for a positive source");

   AST_CARRY_SET: assert property (@(posedge clock) disable iff (srst)
      exec && cmd_next.op == SHU_OP_SRAW && amount_gpr_reg[5]
         && src_gpr_reg[31]
      |=> fixed_point_exception_reg[SHU_FXER_CA_BIT])
      else $error("Carry clear after a negative source lost ones");

   AST_SRAWI_ZERO: assert property (@(posedge clock) disable iff (srst)
      exec && cmd_next.op == SHU_OP_SRAWI && cmd_next.imm_count_field == 5'h0
      |=> dest_gpr_reg == $past(src_gpr_reg)
          && !fixed_point_exception_reg[SHU_FXER_CA_BIT])
      else $error("Zero immediate count not a copy");

   AST_SRAW_ZERO: assert property (@(posedge clock) disable iff (srst)
      exec && cmd_next.op == SHU_OP_SRAW && amount_gpr_reg[5:0] == 6'h00
      |=> dest_gpr_reg == $past(src_gpr_reg)
          && !fixed_point_exception_reg[SHU_FXER_CA_BIT])
      else $error("Zero amount not a copy");

   AST_SRAW_BIG: assert property (@(posedge clock) disable iff (srst)
      exec && cmd_next.op == SHU_OP_SRAW && amount_gpr_reg[5]
      |=> dest_gpr_reg == {32{$past(src_gpr_reg[31])}})
      else $error("Arithmetic shift of 32 or more not all sign");

   AST_PLAIN_COND: assert property (@(posedge clock) disable iff (srst)
      exec && !cmd_next.dot |=> $stable(result_cond_field_reg))
      else $error("Plain form touched the condition field");

   AST_LOGIC_CARRY: assert property (@(posedge clock) disable iff (srst)
      exec && !cmd_next.op[1]
      |=> $stable(fixed_point_exception_reg))
      else $error("Logical shift changed the carry");

endmodule

// *** shu_pkg.sv ***
// Behaviour
// - Left shift by amount bits, zero fill right
// - Right logical shift, zero fill left
// - Logical shifts by 32 or more give zero
// - Immediate arithmetic shift uses five-bit count
// - Arithmetic shifts fill left with sign copies
// - Carry set when negative and ones lost
// - Immediate count zero: copy source, clear carry
// - Arithmetic register amount zero: copy source, clear carry
// - Arithmetic amount 32 or more: all sign
// - Arithmetic amount below 32 shifts, sign fill
// - Dot forms update condition field, others not
package shu_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int unsigned SHU_ADDR_W = 8;
   localparam int unsigned SHU_DATA_W = 32;
   localparam int unsigned SHU_STRB_W = SHU_DATA_W / 8;

   localparam logic [1:0] SHU_RESP_OKAY   = 2'h0;
   localparam logic [1:0] SHU_RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [SHU_ADDR_W-1:0] SHU_OFS_SRC    = 8'h00;
   localparam logic [SHU_ADDR_W-1:0] SHU_OFS_AMOUNT = 8'h04;
   localparam logic [SHU_ADDR_W-1:0] SHU_OFS_CMD    = 8'h08;
   localparam logic [SHU_ADDR_W-1:0] SHU_OFS_DEST   = 8'h0C;
   localparam logic [SHU_ADDR_W-1:0] SHU_OFS_FXER   = 8'h10;
   localparam logic [SHU_ADDR_W-1:0] SHU_OFS_COND   = 8'h14;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned SHU_AMT_BIG_BIT  = 5;
   localparam int unsigned SHU_FXER_CA_BIT  = 0;
   localparam int unsigned SHU_FXER_SO_BIT  = 1;
   localparam logic [31:0] SHU_RST_WORD     = 32'h0000_0000;
   localparam logic [3:0]  SHU_RST_COND     = 4'h0;

   typedef enum logic [1:0]
   {
      SHU_OP_SLW   = 2'b00,
      SHU_OP_SRW   = 2'b01,
      SHU_OP_SRAWI = 2'b10,
      SHU_OP_SRAW  = 2'b11
   } shu_op_e;

   typedef struct packed
   {
      logic [18:0] rsvd_hi;
      logic [4:0]  imm_count_field;
      logic [4:0]  rsvd_lo;
      logic        dot;
      shu_op_e     op;
   } shu_cmd_s;

   typedef struct packed
   {
      logic [31:0] value;
      logic        carry;
      logic        carry_upd;
   } shu_res_s;

   // ----------------------------------------------------------------
   // AXI4-Lite carriers
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic                  awvalid;
      logic [SHU_ADDR_W-1:0] awaddr;
      logic                  wvalid;
      logic [SHU_DATA_W-1:0] wdata;
      logic [SHU_STRB_W-1:0] wstrb;
      logic                  bready;
      logic                  arvalid;
      logic [SHU_ADDR_W-1:0] araddr;
      logic                  rready;
   } shu_axi_req_s;

   typedef struct packed
   {
      logic                  awready;
      logic                  wready;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arready;
      logic                  rvalid;
      logic [SHU_DATA_W-1:0] rdata;
      logic [1:0]            rresp;
   } shu_axi_rsp_s;

endpackage

// *** shu_host.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Register-bus master in place of decode and writeback
// ----------------------------------------------------------------
module shu_host
(
   input  wire logic                  clock,
   input  wire shu_pkg::shu_axi_rsp_s axi_rsp,
   output      shu_pkg::shu_axi_req_s axi_req,
   output      logic                  hung
);
   import shu_pkg::*;

   initial
   begin
      axi_req = '0;
      hung    = 1'b0;
   end

   // Only the four shift codes go out; immediate logical forms are rotates
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      logic ta;
      logic tw;
      logic tb;
      int   n;
      @(posedge clock);
      axi_req.awaddr  <= a;
      axi_req.wdata   <= d;
      axi_req.wstrb   <= s;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid  <= 1'b1;
      axi_req.bready  <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(negedge clock);
         ta = axi_req.awvalid && axi_rsp.awready;
         tw = axi_req.wvalid && axi_rsp.wready;
         tb = axi_req.bready && axi_rsp.bvalid;
         @(posedge clock);
         if (ta)
            axi_req.awvalid <= 1'b0;
         if (tw)
            axi_req.wvalid <= 1'b0;
         if (tb)
         begin
            axi_req.bready <= 1'b0;
            return;
         end
      end
      // Blocking, so the caller sees the hang on return
      hung = 1'b1;
   endtask

   task automatic rd(input logic [7:0] a);
      logic ta;
      logic tr;
      int   n;
      @(posedge clock);
      axi_req.araddr  <= a;
      axi_req.arvalid <= 1'b1;
      axi_req.rready  <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(negedge clock);
         ta = axi_req.arvalid && axi_rsp.arready;
         tr = axi_req.rready && axi_rsp.rvalid;
         @(posedge clock);
         if (ta)
            axi_req.arvalid <= 1'b0;
         if (tr)
         begin
            axi_req.rready <= 1'b0;
            return;
         end
      end
      hung = 1'b1;
   endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
   import shu_pkg::*;

   // ----------------------------------------------------------------
   // Signals and shadow state
   // ----------------------------------------------------------------
   logic         clock;
   logic         srst;
   shu_axi_req_s axi_req;
   shu_axi_rsp_s axi_rsp;
   logic         hung;
   int           fails;
   int           tests_run;
   logic [33:0]  exp_r[$];
   logic [1:0]   exp_b[$];
   logic [31:0]  fx_m;
   logic [31:0]  dest_m;
   logic [3:0]   cond_m;

   shu_shift_unit dut
   (
      .clock   (clock),
      .srst    (srst),
      .axi_req (axi_req),
      .axi_rsp (axi_rsp)
   );

   shu_host u_host
   (
      .clock   (clock),
      .axi_rsp (axi_rsp),
      .axi_req (axi_req),
      .hung    (hung)
   );

   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // ----------------------------------------------------------------
   // Checking
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [33:0] e,
                      input logic [33:0] s);
      tests_run++;
      if (s !== e)
      begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask

   // Answers stand until the ready edge, so one look per answer
   always @(negedge clock)
   begin
      if (axi_req.bready && axi_rsp.bvalid)
         chk("bresp", {32'h0000_0000, exp_b.pop_front()},
             {32'h0000_0000, axi_rsp.bresp});
      if (axi_req.rready && axi_rsp.rvalid)
         chk("rdata", exp_r.pop_front(), {axi_rsp.rresp, axi_rsp.rdata});
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic w(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] rs);
      exp_b.push_back(rs);
      u_host.wr(a, d, 4'hF);
      if (hung)
      begin
         fails++;
         end_sim();
      end
   endtask

   task automatic r(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] rs);
      exp_r.push_back({rs, d});
      u_host.rd(a);
      if (hung)
      begin
         fails++;
         end_sim();
      end
   endtask

   // ----------------------------------------------------------------
   // Reference shifter, carry in bit 32
   // ----------------------------------------------------------------
   function automatic logic [32:0] model(input logic [1:0] op,
      input logic [31:0] s, input logic [5:0] amt, input logic [4:0] imm);
      logic [31:0] v;
      logic [31:0] lost;
      logic [5:0]  k;
      k = (op == 2'h2) ? {1'b0, imm} : amt;
      lost = k[5] ? s : (s & ~(32'hFFFF_FFFF << k[4:0]));
      case (op)
         2'h0:    v = k[5] ? 32'h0000_0000 : s << k[4:0];
         2'h1:    v = k[5] ? 32'h0000_0000 : s >> k[4:0];
         default: v = k[5] ? {32{s[31]}} : 32'($signed(s) >>> k[4:0]);
      endcase
      return {s[31] && (lost != 32'h0000_0000), v};
   endfunction

   task automatic run_op(input logic [1:0] op, input logic [5:0] amt,
                         input logic [31:0] s);
      logic [32:0] e;
      logic        dt;
      logic [1:0]  fx;
      dt = 1'($urandom);
      fx = 2'($urandom);
      w(SHU_OFS_SRC, s, SHU_RESP_OKAY);
      w(SHU_OFS_AMOUNT, {26'h000_0000, amt}, SHU_RESP_OKAY);
      w(SHU_OFS_FXER, {30'h0000_0000, fx}, SHU_RESP_OKAY);
      fx_m = {30'h0000_0000, fx};
      e = model(op, s, amt, amt[4:0]);
      dest_m = e[31:0];
      // Logical forms keep the random carry written above
      if (op[1])
         fx_m[0] = e[32];
      if (dt)
         cond_m = {e[31], !e[31] && e[31:0] != 32'h0000_0000,
                   e[31:0] == 32'h0000_0000, fx_m[1]};
      w(SHU_OFS_CMD, {19'h0_0000, amt[4:0], 5'h00, dt, op}, SHU_RESP_OKAY);
      r(SHU_OFS_DEST, dest_m, SHU_RESP_OKAY);
      r(SHU_OFS_FXER, fx_m, SHU_RESP_OKAY);
      r(SHU_OFS_COND, {28'h000_0000, cond_m}, SHU_RESP_OKAY);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [5:0]  amts [6];
      logic [5:0]  a;
      logic [31:0] s;
      int          op;
      int          i;
      srst      = 1'b1;
      fails     = 0;
      tests_run = 0;
      fx_m      = 32'h0000_0000;
      dest_m    = 32'h0000_0000;
      cond_m    = 4'h0;
      amts      = '{6'h00, 6'h01, 6'h1F, 6'h20, 6'h3F, 6'h00};
      void'($urandom(59));
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      r(SHU_OFS_DEST, 32'h0000_0000, SHU_RESP_OKAY);
      r(SHU_OFS_FXER, 32'h0000_0000, SHU_RESP_OKAY);
      r(SHU_OFS_COND, 32'h0000_0000, SHU_RESP_OKAY);
      // Boundary amounts first, a random one last, sign alternating
      for (op = 0; op < 4; op++)
         for (i = 0; i < 6; i++)
         begin
            a = (i == 5) ? 6'($urandom) : amts[i];
            s = $urandom;
            s[31] = i[0];
            // One lost bit makes a negative source set the carry
            if (i == 1)
               s[0] = 1'b1;
            run_op(2'(op), a, s);
         end
      // Read-only result and unmapped place refuse and keep state
      w(SHU_OFS_DEST, ~dest_m, SHU_RESP_SLVERR);
      r(8'h40, 32'h0000_0000, SHU_RESP_SLVERR);
      r(SHU_OFS_DEST, dest_m, SHU_RESP_OKAY);
      end_sim();
   end
endmodule
